/* File: rtl/pmwctl_defs.vh */
`ifndef PMWCTL_DEFS_VH
`define PMWCTL_DEFS_VH
`define PMW_ADDR_WATCHDOG_CONTROL      4'h0
`define PMW_ADDR_MODE      4'h4
`define PMW_ADDR_STATUS    4'h8
`define PMW_ADDR_WAKE      4'hC
`define PMW_ADDR_W         4
`define PMW_WATCHDOG_CONTROL_RESET     8'h53
`define PMW_KEY_OFF        5'h15
`define PMW_KEY_ON         5'h0A
`define PMW_KEY_HI         7
`define PMW_KEY_LO         3
`define PMW_SEL_HI         2
`define PMW_SEL_LO         0
`define PMW_WDT_MIN_LOG2   8
`define PMW_WDT_MAX_LOG2   18
`define PMW_KEY_DLY_LS     2'h2
`define PMW_STAB_CYCLES    4'h4
`define PMW_RESP_OKAY      2'h0
`define PMW_RESP_SLVERR    2'h2
`endif

/* File: rtl/pmwctl_sync.v */
`timescale 1ns/1ps
module pmwctl_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         srst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  always @(posedge clk) begin
    if (srst) begin
      s1_reg <= {W{1'b1}};
      s2_reg <= {W{1'b1}};
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end
  assign q = s2_reg;
endmodule

/* File: rtl/pmwctl_top.v */
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pmwctl_defs.vh"
module pmwctl_top #(
  parameter NPA = 8,
  parameter NIRQ = 4
) (
  input  wire            clk,
  input  wire            srst,
  input  wire            ls_tick,
  input  wire            wdt_always_on,
  input  wire            halt_exec,
  input  wire            clrwdt_exec,
  input  wire            ext_reset_n,
  input  wire [NPA-1:0]  porta_in,
  input  wire [NIRQ-1:0] irq_req,
  input  wire [NIRQ-1:0] irq_en,
  input  wire            stack_full,
  output reg             sysclk_en,
  output reg             timebase_en,
  output reg             subclk_en,
  output reg             core_stall,
  output reg             irq_vector,
  output reg             full_reset,
  output reg             wdt_reset,
  output reg             key_reset,
  output reg             pc_sp_reset,
  output reg  [2:0]      mode_state,
  input  wire [31:0]     s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output reg             s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output reg             s_axi_wready,
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [31:0]     s_axi_araddr,
  input  wire            s_axi_arvalid,
  output reg             s_axi_arready,
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready
);
  localparam ST_RUN   = 3'd0;
  localparam ST_DEEP  = 3'd1;
  localparam ST_LPWDT = 3'd2;
  localparam ST_HSUB  = 3'd3;
  localparam ST_HFULL = 3'd4;
  localparam ST_STAB  = 3'd5;

  reg  [7:0]     watchdog_control_reg;
  reg            idle_select_reg;
  reg            idle_sysclk_keep_reg;
  reg            powerdown_flag_reg;
  reg            watchdog_timeout_flag_reg;
  reg            wdt_key_reset_flag_reg;
  reg  [NPA-1:0] porta_wake_enable_reg;
  reg  [NPA-1:0] pa_prev_reg;
  reg  [NIRQ-1:0] irq_prev_reg;
  reg  [NIRQ-1:0] irq_mask_reg;
  reg  [18:0]    wdt_cnt_reg;
  reg  [1:0]     key_dly_reg;
  reg  [3:0]     stab_reg;
  reg            irq_wake_reg;
  reg  [3:0]     aw_addr_reg;
  reg  [31:0]    w_data_reg;
  reg  [3:0]     w_strb_reg;
  reg            aw_have_reg;
  reg            w_have_reg;
  wire [NPA-1:0] pa_s;
  wire           ext_rst_s_n;
  wire [NIRQ-1:0] irq_s;

  // Pins arrive asynchronously to clk
  pmwctl_sync #(.W(NPA + 1 + NIRQ)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({porta_in, ext_reset_n, irq_req}),
    .q    ({pa_s, ext_rst_s_n, irq_s})
  );

  wire [4:0] key = watchdog_control_reg[`PMW_KEY_HI:`PMW_KEY_LO];
  wire [2:0] psel = watchdog_control_reg[`PMW_SEL_HI:`PMW_SEL_LO];
  wire key_valid = (key == `PMW_KEY_ON) || (key == `PMW_KEY_OFF);
  wire wdt_on = (key == `PMW_KEY_ON) || (wdt_always_on && key == `PMW_KEY_OFF);
  wire sleeping = (mode_state == ST_DEEP) || (mode_state == ST_LPWDT) ||
                  (mode_state == ST_HSUB) || (mode_state == ST_HFULL);

  // Overflow tap; codes 010 and 011 share 2^12
  reg [4:0] tap;
  always @* begin
    case (psel)
      3'd0: tap = 5'd8;
      3'd1: tap = 5'd10;
      3'd2: tap = 5'd12;
      3'd3: tap = 5'd12;
      3'd4: tap = 5'd15;
      3'd5: tap = 5'd16;
      3'd6: tap = 5'd17;
      default: tap = 5'd18;
    endcase
  end
  wire wdt_ovf = wdt_cnt_reg[tap];

  // Falling edge on enabled pin, sampled on clk which runs in all states
  wire pa_wake = |(pa_prev_reg & ~pa_s & porta_wake_enable_reg);
  // Only fresh requests not pending at halt wake
  wire [NIRQ-1:0] irq_new = irq_s & ~irq_prev_reg & ~irq_mask_reg;
  wire irq_wake = |irq_new;
  // Enabled and stack room means vector
  wire irq_serv = |(irq_new & irq_en) && !stack_full;

  wire wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire ovf_ev = wdt_on && wdt_ovf && (mode_state != ST_DEEP);

  always @(posedge clk) begin
    if (srst) begin
      mode_state <= ST_RUN;
      sysclk_en <= 1'b1;
      timebase_en <= 1'b1;
      subclk_en <= 1'b1;
      core_stall <= 1'b0;
      irq_vector <= 1'b0;
      full_reset <= 1'b0;
      wdt_reset <= 1'b0;
      key_reset <= 1'b0;
      pc_sp_reset <= 1'b0;
      wdt_cnt_reg <= 19'h0_0000;
      key_dly_reg <= 2'h0;
      stab_reg <= 4'h0;
      irq_wake_reg <= 1'b0;
      irq_mask_reg <= {NIRQ{1'b0}};
      irq_prev_reg <= {NIRQ{1'b1}};
      pa_prev_reg <= {NPA{1'b1}};
      powerdown_flag_reg <= 1'b0;
      watchdog_timeout_flag_reg <= 1'b0;
    end else begin
      pa_prev_reg <= pa_s;
      irq_prev_reg <= irq_s;
      irq_vector <= 1'b0;
      full_reset <= 1'b0;
      wdt_reset <= 1'b0;
      key_reset <= 1'b0;
      pc_sp_reset <= 1'b0;
      // Bad key counted in slow ticks
      if (key_valid) begin
        key_dly_reg <= 2'h0;
      end else if (ls_tick) begin
        if (key_dly_reg == `PMW_KEY_DLY_LS) begin
          key_reset <= 1'b1;
          key_dly_reg <= 2'h0;
        end else begin
          key_dly_reg <= key_dly_reg + 2'h1;
        end
      end
      // Watchdog counts slow ticks when enabled
      if (clrwdt_exec || halt_exec && !sleeping || ovf_ev || !wdt_on) begin
        wdt_cnt_reg <= 19'h0_0000;
      end else if (ls_tick) begin
        wdt_cnt_reg <= wdt_cnt_reg + 19'h0_0001;
      end
      if (clrwdt_exec && !sleeping) begin
        powerdown_flag_reg <= 1'b0;
      end
      case (mode_state)
        ST_RUN: begin
          core_stall <= 1'b0;
          if (halt_exec) begin
            powerdown_flag_reg <= 1'b1;
            watchdog_timeout_flag_reg <= 1'b0;
            irq_mask_reg <= irq_s;
            core_stall <= 1'b1;
            sysclk_en <= 1'b0;
            if (!idle_select_reg && !wdt_on) begin
              mode_state <= ST_DEEP;
              timebase_en <= 1'b0;
              subclk_en <= 1'b0;
            end else if (!idle_select_reg) begin
              mode_state <= ST_LPWDT;
              timebase_en <= 1'b0;
            end else if (!idle_sysclk_keep_reg) begin
              // Time base and sub clock on
              mode_state <= ST_HSUB;
            end else begin
              mode_state <= ST_HFULL;
              sysclk_en <= 1'b1;
            end
          end else if (ovf_ev) begin
            watchdog_timeout_flag_reg <= 1'b1;
            wdt_reset <= 1'b1;
          end
        end
        ST_DEEP, ST_LPWDT, ST_HSUB, ST_HFULL: begin
          if (!ext_rst_s_n) begin
            full_reset <= 1'b1;
            mode_state <= ST_STAB;
            stab_reg <= `PMW_STAB_CYCLES;
            irq_wake_reg <= 1'b0;
          end else if (ovf_ev) begin
            // Flag set, wdt_reset and pc_sp_reset pulse, no full_reset
            watchdog_timeout_flag_reg <= 1'b1;
            wdt_reset <= 1'b1;
            pc_sp_reset <= 1'b1;
            mode_state <= ST_STAB;
            stab_reg <= `PMW_STAB_CYCLES;
            irq_wake_reg <= 1'b0;
          end else if (pa_wake || irq_wake) begin
            // Unserved irq stays pending at source
            irq_wake_reg <= irq_serv;
            mode_state <= ST_STAB;
            stab_reg <= `PMW_STAB_CYCLES;
          end
        end
        ST_STAB: begin
          sysclk_en <= 1'b1;
          timebase_en <= 1'b1;
          subclk_en <= 1'b1;
          if (stab_reg == 4'h0) begin
            core_stall <= 1'b0;
            irq_vector <= irq_wake_reg;
            mode_state <= ST_RUN;
          end else begin
            stab_reg <= stab_reg - 4'h1;
          end
        end
        default: mode_state <= ST_RUN;
      endcase
    end
  end

  // AXI4-Lite write path
  wire [7:0] wb = w_data_reg[7:0];
  always @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMW_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      watchdog_control_reg <= `PMW_WATCHDOG_CONTROL_RESET;
      idle_select_reg <= 1'b0;
      idle_sysclk_keep_reg <= 1'b0;
      porta_wake_enable_reg <= {NPA{1'b0}};
      wdt_key_reset_flag_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        // Upper address bits force an unmapped offset, so nothing aliases
        aw_addr_reg <= s_axi_awaddr[3:0] | {4{|s_axi_awaddr[31:`PMW_ADDR_W]}};
        aw_have_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PMW_RESP_OKAY;
        if (w_strb_reg[0]) begin
          case (aw_addr_reg)
            `PMW_ADDR_WATCHDOG_CONTROL: watchdog_control_reg <= wb;
            `PMW_ADDR_MODE: begin
              idle_select_reg <= wb[0];
              idle_sysclk_keep_reg <= wb[1];
            end
            `PMW_ADDR_STATUS: begin
              if (!wb[2]) begin
                wdt_key_reset_flag_reg <= 1'b0;
              end
            end
            `PMW_ADDR_WAKE: porta_wake_enable_reg <= w_data_reg[NPA-1:0];
            default: s_axi_bresp <= `PMW_RESP_SLVERR;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (key_reset) begin
        wdt_key_reset_flag_reg <= 1'b1;
        watchdog_control_reg <= `PMW_WATCHDOG_CONTROL_RESET;
      end
    end
  end

  // AXI4-Lite read path
  always @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PMW_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `PMW_RESP_OKAY;
        case (s_axi_araddr[3:0] | {4{|s_axi_araddr[31:`PMW_ADDR_W]}})
          `PMW_ADDR_WATCHDOG_CONTROL: s_axi_rdata <= {24'h00_0000, watchdog_control_reg};
          `PMW_ADDR_MODE: s_axi_rdata <= {27'h000_0000, mode_state,
                                          idle_sysclk_keep_reg, idle_select_reg};
          `PMW_ADDR_STATUS: s_axi_rdata <= {29'h0000_0000, wdt_key_reset_flag_reg,
                                            watchdog_timeout_flag_reg,
                                            powerdown_flag_reg};
          `PMW_ADDR_WAKE: s_axi_rdata <= {{(32-NPA){1'b0}}, porta_wake_enable_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PMW_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

/* File: verification/pmwctl_top_assertions.sv */
`timescale 1ns/1ps
module pmwctl_top_assertions (
  input wire       clk,
  input wire       srst,
  input wire       halt_exec,
  input wire       core_stall,
  input wire       irq_vector,
  input wire       sysclk_en,
  input wire       timebase_en,
  input wire       subclk_en,
  input wire [2:0] mode_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_HALT_ENTRY: assert property ((mode_state == 3'h0) && halt_exec |=>
    core_stall && (mode_state inside {[3'h1:3'h4]})) else $error("halt did not stall");
  AST_DEEP_CLOCKS: assert property (mode_state == 3'h1 |-> !sysclk_en && !timebase_en)
    else $error("deep stop clocks wrong");
  AST_LP_CLOCKS: assert property (mode_state == 3'h2 |-> !sysclk_en && !timebase_en)
    else $error("low power clocks wrong");
  AST_HOLD_SUB: assert property (mode_state == 3'h3 |-> !sysclk_en && timebase_en && subclk_en)
    else $error("hold sub clocks wrong");
  AST_HOLD_FULL: assert property (mode_state == 3'h4 |-> sysclk_en && timebase_en && subclk_en)
    else $error("hold full clocks wrong");
  AST_WAKE_ONLY: assert property ((mode_state inside {[3'h1:3'h4]}) |=>
    mode_state == $past(mode_state) || mode_state == 3'h5) else $error("bad sleep exit");
  AST_STAB_HOLD: assert property ($rose(mode_state == 3'h5) |->
    core_stall [*4] ##[1:4] !core_stall) else $error("stall release wrong");
  AST_IRQ_VECTOR: assert property (irq_vector |-> !core_stall && $past(core_stall))
    else $error("vector outside wake");
endmodule

bind pmwctl_top pmwctl_top_assertions pmwctl_top_assertions_i (
  .clk(clk), .srst(srst), .halt_exec(halt_exec), .core_stall(core_stall),
  .irq_vector(irq_vector), .sysclk_en(sysclk_en), .timebase_en(timebase_en),
  .subclk_en(subclk_en), .mode_state(mode_state));

/* File: verification/pmwctl_core_model.sv */
`timescale 1ns/1ps
// Core side: turns one-cycle requests into instruction pulses
module pmwctl_core_model (
  input  wire clk,
  input  wire srst,
  input  wire halt_req,
  input  wire clr_req,
  output reg  halt_exec,
  output reg  clrwdt_exec,
  output reg  ls_tick
);
  reg [2:0] div_reg;
  // Slow clock stand-in, one tick per 8 cycles keeps watchdog runs short
  always @(posedge clk) begin
    div_reg     <= srst ? 3'h0 : div_reg + 3'h1;
    ls_tick     <= (div_reg == 3'h7) && !srst;
    halt_exec   <= halt_req && !srst;
    clrwdt_exec <= clr_req && !srst;
  end
endmodule

/* File: verification/power_mode_wake_watchdog_ctl_tb.sv */
`timescale 1ns/1ps
`include "pmwctl_defs.vh"
module power_mode_wake_watchdog_ctl_tb;
  reg         clk, srst, halt_req, clr_req, aon, ext_rst_n, stack_full;
  reg  [7:0]  pa;
  reg  [3:0]  irq, irq_en;
  reg  [31:0] awaddr, wdata, araddr, d, r;
  reg         awv, wv, bready, arv, rready;
  reg  [1:0]  rs;
  wire        halt_exec, clr_exec, ls_tick, sys_en, tb_en, sub_en, stall, ivec;
  wire        f_rst, w_rst, k_rst, ps_rst, awr, wr_rdy, bv, arr, rv;
  wire [2:0]  mode;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     n_fail, comparisons, t, i, j, ev[0:4];
  reg  [31:0] rows [0:4] = '{32'h00AB_0010, 32'h0053_0020, 32'h01AB_0020,
                             32'h0053_0131, 32'h0053_0343};

  pmwctl_core_model pmwctl_core_model_i (.clk(clk), .srst(srst), .halt_req(halt_req),
    .clr_req(clr_req), .halt_exec(halt_exec), .clrwdt_exec(clr_exec), .ls_tick(ls_tick));
  pmwctl_top pmwctl_top_i (.clk(clk), .srst(srst), .ls_tick(ls_tick), .wdt_always_on(aon),
    .halt_exec(halt_exec), .clrwdt_exec(clr_exec), .ext_reset_n(ext_rst_n), .porta_in(pa),
    .irq_req(irq), .irq_en(irq_en), .stack_full(stack_full), .sysclk_en(sys_en),
    .timebase_en(tb_en), .subclk_en(sub_en), .core_stall(stall), .irq_vector(ivec),
    .full_reset(f_rst), .wdt_reset(w_rst), .key_reset(k_rst), .pc_sp_reset(ps_rst),
    .mode_state(mode), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Pulses are counted so that short ones are never missed
  always @(posedge clk) begin
    if (!srst) begin
      ev[0] <= ev[0] + f_rst;
      ev[1] <= ev[1] + w_rst;
      ev[2] <= ev[2] + k_rst;
      ev[3] <= ev[3] + ps_rst;
      ev[4] <= ev[4] + ivec;
    end
  end

  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(posedge clk);
    awaddr <= {24'h0, a};
    wdata <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bv && t < 50);
    if (t >= 50) begin
      n_fail++;
      $display("ERROR %0t write response timeout", $time);
    end
    bready <= 1'b0;
    rs = bresp;
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    araddr <= {24'h0, a};
    arv <= 1'b1;
    rready <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      if (arr) arv <= 1'b0;
    end while (!rv && t < 50);
    if (t >= 50) begin
      n_fail++;
      $display("ERROR %0t read response timeout", $time);
    end
    rready <= 1'b0;
    d = rdata;
    rs = rresp;
  endtask
  task hlt;
    @(posedge clk) halt_req <= 1'b1;
    @(posedge clk) halt_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Bounded wait for the core to be released
  task ww;
    t = 0;
    while (stall !== 1'b0 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    if (t >= 3000) begin
      n_fail++;
      $display("ERROR %0t wake timeout", $time);
    end
    @(posedge clk);
  endtask

  initial begin
    #400000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test;
  end

  initial begin
    {halt_req, clr_req, aon, stack_full, awv, wv, bready, arv, rready} = 9'h0;
    {awaddr, wdata, araddr, irq, irq_en} = 104'h0;
    {n_fail, comparisons, ev[0], ev[1], ev[2], ev[3], ev[4]} = 224'h0;
    srst = 1'b1;
    ext_rst_n = 1'b1;
    pa = 8'hFF;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(8'h0);
    chk(d, 32'h0000_0053);
    wr(8'hC, 8'h01);
    for (i = 0; i < 5; i++) begin
      r = rows[i];
      aon <= r[24];
      wr(8'h0, r[23:16]);
      wr(8'h4, r[15:8]);
      hlt;
      chk(mode, r[7:4]);
      chk({sys_en, tb_en}, r[1:0]);
      chk(stall, 1);
      rd(8'h8);
      chk(d[1:0], 2'h1);
      pa <= 8'hFE;
      ww;
      pa <= 8'hFF;
      chk(mode, 0);
      @(posedge clk) clr_req <= 1'b1;
      @(posedge clk) clr_req <= 1'b0;
      repeat (2) @(posedge clk);
      rd(8'h8);
      chk(d[0], 0);
      $display("mode row %0d done", i);
    end
    aon <= 1'b0;
    wr(8'h0, 8'h50);
    wr(8'h4, 8'h0);
    i = ev[1];
    j = ev[3];
    hlt;
    ww;
    chk(ev[1] - i, 1);
    chk(ev[3] - j, 1);
    rd(8'h8);
    chk(d[1:0], 2'h3);
    wr(8'h0, 8'h53);
    $display("sleep timeout done");
    i = ev[0];
    hlt;
    rd(8'h8);
    chk(d[1:0], 2'h1);
    ext_rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    ext_rst_n <= 1'b1;
    ww;
    chk(ev[0] - i, 1);
    $display("external wake done");
    irq_en <= 4'h3;
    irq <= 4'h1;
    hlt;
    repeat (20) @(posedge clk);
    chk(stall, 1);
    irq <= 4'h0;
    repeat (4) @(posedge clk);
    irq <= 4'h1;
    repeat (10) @(posedge clk);
    chk(stall, 1);
    irq <= 4'h3;
    i = ev[4];
    ww;
    chk(ev[4] - i, 1);
    irq <= 4'h0;
    stack_full <= 1'b1;
    hlt;
    irq <= 4'h1;
    i = ev[4];
    ww;
    chk(ev[4] - i, 0);
    irq <= 4'h0;
    $display("interrupt wake done");
    i = ev[2];
    wr(8'h0, 8'h03);
    t = 0;
    while (ev[2] == i && t < 100) begin
      @(posedge clk);
      t++;
    end
    chk(t > 8 && t < 40, 1);
    repeat (2) @(posedge clk);
    rd(8'h8);
    chk(d[2], 1);
    rd(8'h0);
    chk(d, 32'h0000_0053);
    wr(8'h8, 8'h0);
    chk(rs, `PMW_RESP_OKAY);
    rd(8'h8);
    chk(d[2], 0);
    rd(8'h10);
    chk(rs, `PMW_RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h10, 8'h00);
    chk(rs, `PMW_RESP_SLVERR);
    rd(8'h0);
    chk(d, 32'h0000_0053);
    $display("key and bus done");
    stop_test;
  end
endmodule
